// ==== src/dtc_pkg.sv ====
// Purpose: Shared constants for the dual timer/counter block.
// Assumes: Wishbone classic slave, 32-bit data, word-aligned registers.
// Notes: Offsets are byte addresses equal to four times the register index.
package dtc_pkg;
  localparam int unsigned DTC_CLK_HZ = 20000000;
  localparam int unsigned DTC_TICK_DIV = 2;
  localparam int unsigned DTC_WAVE_DIV = 64;
  localparam int unsigned DTC_ADR_W = 12;
  localparam logic [7:0] DTC_IDX_CTRL = 8'h88;
  localparam logic [7:0] DTC_IDX_MODE = 8'h89;
  localparam logic [7:0] DTC_IDX_T0L = 8'h8A;
  localparam logic [7:0] DTC_IDX_T1L = 8'h8B;
  localparam logic [7:0] DTC_IDX_T0H = 8'h8C;
  localparam logic [7:0] DTC_IDX_T1H = 8'h8D;
  localparam logic [7:0] DTC_IDX_PINSEL = 8'hA6;
  localparam logic [7:0] DTC_IDX_ACK = 8'hF0;
  localparam logic [7:0] DTC_IDX_ISTAT = 8'hF1;
  localparam logic [7:0] DTC_IDX_IMASK = 8'hF2;
  localparam int unsigned DTC_TF1_BIT = 7;
  localparam int unsigned DTC_TR1_BIT = 6;
  localparam int unsigned DTC_TF0_BIT = 5;
  localparam int unsigned DTC_TR0_BIT = 4;
  localparam int unsigned DTC_WAVE_EN_BIT = 0;
  localparam int unsigned DTC_PINSEL_MASK_BITS = 8;
  localparam logic [7:0] DTC_PINSEL_MASK = 8'h71;
  localparam logic [1:0] DTC_MODE_13 = 2'h0;
  localparam logic [1:0] DTC_MODE_16 = 2'h1;
  localparam logic [1:0] DTC_MODE_RELOAD = 2'h2;
  localparam logic [1:0] DTC_MODE_SPLIT = 2'h3;
  localparam logic [7:0] DTC_BYTE_ZERO = 8'h00;
  localparam logic [7:0] DTC_BYTE_MAX = 8'hFF;
  localparam logic [4:0] DTC_PRE_MAX = 5'h1F;
  localparam logic [31:0] DTC_WORD_ZERO = 32'h0000_0000;
endpackage : dtc_pkg

// ==== src/dtc_edge_sync.sv ====
// Purpose: Two-stage synchroniser with falling-edge pulse.
// Assumes: Input is asynchronous to clk.
// Notes: The edge detector reads only the second and third stages.
`timescale 1ns/1ns
`default_nettype none
module dtc_edge_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pinIn,
  output logic level,
  output logic fallPulse
);
  logic meta;
  logic sync;
  logic prev;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= pinIn;
      sync <= meta;
      prev <= sync;
    end
  end
  assign level = sync;
  assign fallPulse = prev & ~sync;
endmodule : dtc_edge_sync
`default_nettype wire

// ==== src/dtc_wave_div.sv ====
// Purpose: Divides overflow pulses into a square wave.
// Assumes: DIV is even; the output toggles every DIV/2 pulses.
// Notes: Counter holds while disabled so the pin restarts cleanly.
`timescale 1ns/1ns
`default_nettype none
module dtc_wave_div #(
  parameter int unsigned DIV = 64
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic pulse,
  output logic wave
);
  localparam int unsigned HALF = DIV / 2;
  localparam int unsigned CW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);
  logic [CW-1:0] cnt;
  logic toggle;
  logic [CW-1:0] next_cnt;
  assign toggle = enable & pulse & (cnt == LAST);
  assign next_cnt = toggle ? '0 : (enable & pulse) ? cnt + 1'b1 : cnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
      wave <= 1'b0;
    end else begin
      cnt <= next_cnt;
      wave <= enable ? (wave ^ toggle) : 1'b0;
    end
  end
endmodule : dtc_wave_div
`default_nettype wire

// ==== src/dual_timer_counter.sv ====
// Purpose: Two 16-bit timer/counters with gating, four modes and wave output.
// Assumes: Wishbone classic slave; count and gate pins are asynchronous.
// Notes: Interrupt status clears on read; vector acknowledge clears flags.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Timer mode counts once per two clocks.
// - Counter mode counts count-pin falling edges.
// - Gate off: run bit alone enables counting.
// - Gate on: run bit and irq pin high.
// - Mode field picks 13, 16, reload, stop.
// - Timer zero split: high byte uses timer one.
// - Count bytes readable, writable, reset to zero.
// - Wave pin carries overflow divided by 64.
module dual_timer_counter
  import dtc_pkg::*;
#(
  parameter int unsigned WAVE_DIV = DTC_WAVE_DIV
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [DTC_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer0_count_pin,
  input wire logic timer1_count_pin,
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  output logic timer0_wave_pin,
  output logic irq
);
  // ==========================================================
  // Registers
  logic [7:0] timer_control;
  logic [7:0] timer_mode_select;
  logic [7:0] timer0_count_low;
  logic [7:0] timer0_count_high;
  logic [7:0] timer1_count_low;
  logic [7:0] timer1_count_high;
  logic [7:0] pin_output_select;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;
  logic tickPhase;

  // ==========================================================
  // Bus decode
  wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [7:0] regIdx = wb_adr_i[9:2];
  wire wrLow = busReq & wb_we_i & wb_sel_i[0];
  wire rdReq = busReq & ~wb_we_i;
  wire wrCtrl = wrLow & (regIdx == DTC_IDX_CTRL);
  wire wrMode = wrLow & (regIdx == DTC_IDX_MODE);
  wire wrT0L = wrLow & (regIdx == DTC_IDX_T0L);
  wire wrT0H = wrLow & (regIdx == DTC_IDX_T0H);
  wire wrT1L = wrLow & (regIdx == DTC_IDX_T1L);
  wire wrT1H = wrLow & (regIdx == DTC_IDX_T1H);
  wire wrPin = wrLow & (regIdx == DTC_IDX_PINSEL);
  wire wrAck = wrLow & (regIdx == DTC_IDX_ACK);
  wire wrMask = wrLow & (regIdx == DTC_IDX_IMASK);
  wire rdStat = rdReq & (regIdx == DTC_IDX_ISTAT);

  // ==========================================================
  // Pin synchronisers
  logic t0Fall;
  logic t1Fall;
  logic gate0Level;
  logic gate1Level;
  dtc_edge_sync u_sync_t0 (
    .clk(clk), .rst(rst), .pinIn(timer0_count_pin), .level(), .fallPulse(t0Fall)
  );
  dtc_edge_sync u_sync_t1 (
    .clk(clk), .rst(rst), .pinIn(timer1_count_pin), .level(), .fallPulse(t1Fall)
  );
  dtc_edge_sync u_sync_g0 (
    .clk(clk), .rst(rst), .pinIn(ext_irq0_pin), .level(gate0Level), .fallPulse()
  );
  dtc_edge_sync u_sync_g1 (
    .clk(clk), .rst(rst), .pinIn(ext_irq1_pin), .level(gate1Level), .fallPulse()
  );

  // ==========================================================
  // Count enables
  wire [1:0] mode0 = timer_mode_select[1:0];
  wire [1:0] mode1 = timer_mode_select[5:4];
  wire gateSel0 = timer_mode_select[3];
  wire gateSel1 = timer_mode_select[7];
  wire cntSel0 = timer_mode_select[2];
  wire cntSel1 = timer_mode_select[6];
  wire run0 = timer_control[DTC_TR0_BIT];
  wire run1 = timer_control[DTC_TR1_BIT];
  wire sysTick = tickPhase;
  // Count pins are sampled each clock; pulses shorter than one clock may be missed.
  wire src0 = cntSel0 ? t0Fall : sysTick;
  wire src1 = cntSel1 ? t1Fall : sysTick;
  wire en0 = run0 & (~gateSel0 | gate0Level);
  wire en1 = run1 & (~gateSel1 | gate1Level);
  wire split = (mode0 == DTC_MODE_SPLIT);
  wire inc0 = en0 & src0;
  wire inc1 = en1 & src1;
  // In split mode the high byte of timer zero borrows timer one's run bit.
  wire inc0H = run1 & sysTick;

  // ==========================================================
  // Timer zero next state
  logic [7:0] next_t0L;
  logic [7:0] next_t0H;
  logic ovf0;
  logic ovf0H;
  always_comb begin
    next_t0L = timer0_count_low;
    next_t0H = timer0_count_high;
    ovf0 = 1'b0;
    ovf0H = 1'b0;
    unique case (mode0)
      DTC_MODE_13: begin
        if (inc0) begin
          next_t0L = {timer0_count_low[7:5], timer0_count_low[4:0] + 5'h01};
          if (timer0_count_low[4:0] == DTC_PRE_MAX) begin
            next_t0H = timer0_count_high + 8'h01;
            ovf0 = (timer0_count_high == DTC_BYTE_MAX);
          end
        end
      end
      DTC_MODE_16: begin
        if (inc0) begin
          {next_t0H, next_t0L} = {timer0_count_high, timer0_count_low} + 16'h0001;
          ovf0 = ({timer0_count_high, timer0_count_low} == 16'hFFFF);
        end
      end
      DTC_MODE_RELOAD: begin
        if (inc0) begin
          ovf0 = (timer0_count_low == DTC_BYTE_MAX);
          next_t0L = ovf0 ? timer0_count_high : timer0_count_low + 8'h01;
        end
      end
      DTC_MODE_SPLIT: begin
        if (inc0) begin
          next_t0L = timer0_count_low + 8'h01;
          ovf0 = (timer0_count_low == DTC_BYTE_MAX);
        end
        if (inc0H) begin
          next_t0H = timer0_count_high + 8'h01;
          ovf0H = (timer0_count_high == DTC_BYTE_MAX);
        end
      end
    endcase
  end

  // ==========================================================
  // Timer one next state
  logic [7:0] next_t1L;
  logic [7:0] next_t1H;
  logic ovf1;
  always_comb begin
    next_t1L = timer1_count_low;
    next_t1H = timer1_count_high;
    ovf1 = 1'b0;
    unique case (mode1)
      DTC_MODE_13: begin
        if (inc1) begin
          next_t1L = {timer1_count_low[7:5], timer1_count_low[4:0] + 5'h01};
          if (timer1_count_low[4:0] == DTC_PRE_MAX) begin
            next_t1H = timer1_count_high + 8'h01;
            ovf1 = (timer1_count_high == DTC_BYTE_MAX);
          end
        end
      end
      DTC_MODE_16: begin
        if (inc1) begin
          {next_t1H, next_t1L} = {timer1_count_high, timer1_count_low} + 16'h0001;
          ovf1 = ({timer1_count_high, timer1_count_low} == 16'hFFFF);
        end
      end
      DTC_MODE_RELOAD: begin
        if (inc1) begin
          ovf1 = (timer1_count_low == DTC_BYTE_MAX);
          next_t1L = ovf1 ? timer1_count_high : timer1_count_low + 8'h01;
        end
      end
      DTC_MODE_SPLIT: begin
        // Timer one is stopped and holds its value.
      end
    endcase
  end
  // While timer zero is split, timer one's flag belongs to timer zero's high byte.
  wire setTf0 = ovf0;
  wire setTf1 = split ? ovf0H : ovf1;

  // ==========================================================
  // Control register with hardware flags; set beats any clear
  wire [7:0] ctrlWr = wrCtrl ? wb_dat_i[7:0] : timer_control;
  wire clrTf0 = wrAck & wb_dat_i[0];
  wire clrTf1 = wrAck & wb_dat_i[1];
  logic [7:0] next_ctrl;
  always_comb begin
    next_ctrl = ctrlWr;
    if (clrTf0) begin
      next_ctrl[DTC_TF0_BIT] = 1'b0;
    end
    if (clrTf1) begin
      next_ctrl[DTC_TF1_BIT] = 1'b0;
    end
    if (setTf0) begin
      next_ctrl[DTC_TF0_BIT] = 1'b1;
    end
    if (setTf1) begin
      next_ctrl[DTC_TF1_BIT] = 1'b1;
    end
  end

  // ==========================================================
  // Interrupt status, cleared by reading it
  wire [1:0] irqSet = {setTf1, setTf0};
  wire [1:0] next_irqStatus = irqSet | (rdStat ? 2'h0 : irqStatus);

  // ==========================================================
  // Sequential state
  always_ff @(posedge clk) begin
    if (rst) begin
      tickPhase <= 1'b0;
      timer_control <= DTC_BYTE_ZERO;
      timer_mode_select <= DTC_BYTE_ZERO;
      pin_output_select <= DTC_BYTE_ZERO;
      irqStatus <= 2'h0;
      irqMask <= 2'h0;
      wb_ack_o <= 1'b0;
    end else begin
      tickPhase <= ~tickPhase;
      timer_control <= next_ctrl;
      timer_mode_select <= wrMode ? wb_dat_i[7:0] : timer_mode_select;
      pin_output_select <= wrPin ? (wb_dat_i[7:0] & DTC_PINSEL_MASK) : pin_output_select;
      irqStatus <= next_irqStatus;
      irqMask <= wrMask ? wb_dat_i[1:0] : irqMask;
      wb_ack_o <= busReq;
    end
  end

  // Software writes win over the count in the same cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      timer0_count_low <= DTC_BYTE_ZERO;
      timer0_count_high <= DTC_BYTE_ZERO;
      timer1_count_low <= DTC_BYTE_ZERO;
      timer1_count_high <= DTC_BYTE_ZERO;
    end else begin
      timer0_count_low <= wrT0L ? wb_dat_i[7:0] : next_t0L;
      timer0_count_high <= wrT0H ? wb_dat_i[7:0] : next_t0H;
      timer1_count_low <= wrT1L ? wb_dat_i[7:0] : next_t1L;
      timer1_count_high <= wrT1H ? wb_dat_i[7:0] : next_t1H;
    end
  end

  // ==========================================================
  // Read mux
  logic [7:0] rdByte;
  always_comb begin
    unique case (regIdx)
      DTC_IDX_CTRL: rdByte = timer_control;
      DTC_IDX_MODE: rdByte = timer_mode_select;
      DTC_IDX_T0L: rdByte = timer0_count_low;
      DTC_IDX_T0H: rdByte = timer0_count_high;
      DTC_IDX_T1L: rdByte = timer1_count_low;
      DTC_IDX_T1H: rdByte = timer1_count_high;
      DTC_IDX_PINSEL: rdByte = pin_output_select;
      DTC_IDX_ISTAT: rdByte = {6'h00, irqStatus};
      DTC_IDX_IMASK: rdByte = {6'h00, irqMask};
      default: rdByte = DTC_BYTE_ZERO;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_dat_o <= DTC_WORD_ZERO;
    end else if (rdReq) begin
      wb_dat_o <= {24'h000000, rdByte};
    end
  end

  assign irq = |(irqStatus & irqMask);

  // ==========================================================
  // Waveform output
  dtc_wave_div #(
    .DIV(WAVE_DIV)
  ) u_wave (
    .clk(clk),
    .rst(rst),
    .enable(pin_output_select[DTC_WAVE_EN_BIT]),
    .pulse(setTf0),
    .wave(timer0_wave_pin)
  );
endmodule : dual_timer_counter
`default_nettype wire

// ==== sim/dtc_sva.sv ====
// Purpose: Port checks for the dual timer/counter.
// Assumes: The master holds each request until it samples ack.
// Notes: Mask and wave enable are mirrored from taken writes.
`timescale 1ns/1ns
`default_nettype none
module dtc_sva
  import dtc_pkg::*;
#(
  parameter int unsigned WAVE_DIV = DTC_WAVE_DIV
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [DTC_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic timer0_count_pin,
  input wire logic timer1_count_pin,
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  input wire logic timer0_wave_pin,
  input wire logic irq
);
  // ====================
  // Mirrors and checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic [7:0] idx = wb_adr_i[9:2];
  wire logic wr = take && wb_we_i && wb_sel_i[0];
  wire logic rdAck = wb_ack_o && !wb_we_i;
  logic waveEn;
  logic [1:0] mask;
  always_ff @(posedge clk) begin
    if (rst) begin
      waveEn <= 1'h0;
      mask <= 2'h0;
    end else if (wr && idx == DTC_IDX_PINSEL) begin
      waveEn <= wb_dat_i[0];
    end else if (wr && idx == DTC_IDX_IMASK) begin
      mask <= wb_dat_i[1:0];
    end
  end
  property p_ackTake; take |=> wb_ack_o; endproperty
  a_ackTake: assert property (p_ackTake) else $error("no ack after request");
  property p_ackOne; wb_ack_o |=> !wb_ack_o; endproperty
  a_ackOne: assert property (p_ackOne) else $error("ack longer than one cycle");
  property p_rdHigh; rdAck |-> wb_dat_o[31:8] == 24'h000000; endproperty
  a_rdHigh: assert property (p_rdHigh) else $error("read data upper bits set");
  property p_unmap; rdAck && idx < DTC_IDX_CTRL |-> wb_dat_o == DTC_WORD_ZERO; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_pinsel;
    rdAck && idx == DTC_IDX_PINSEL |-> (wb_dat_o[7:0] & ~DTC_PINSEL_MASK) == 8'h00
      && wb_dat_o[0] == waveEn;
  endproperty
  a_pinsel: assert property (p_pinsel) else $error("pin select readback wrong");
  property p_rst; disable iff (1'h0) rst |=> !wb_ack_o && !irq && !timer0_wave_pin; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_waveOff; !waveEn [*3] |-> !timer0_wave_pin; endproperty
  a_waveOff: assert property (p_waveOff) else $error("wave pin active while off");
  property p_waveGap; $rose(timer0_wave_pin) |=> (timer0_wave_pin || !waveEn) [*3]; endproperty
  a_waveGap: assert property (p_waveGap) else $error("wave high too briefly");
  property p_irqMask; mask == 2'h0 |-> !irq; endproperty
  a_irqMask: assert property (p_irqMask) else $error("irq with all masked");
  c_write: cover property (wr);
  c_irq: cover property ($rose(irq));
  c_wave: cover property ($rose(timer0_wave_pin));
endmodule : dtc_sva
bind dual_timer_counter dtc_sva #(.WAVE_DIV(WAVE_DIV)) chk (.clk(clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .timer0_count_pin(timer0_count_pin), .timer1_count_pin(timer1_count_pin),
  .ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(ext_irq1_pin),
  .timer0_wave_pin(timer0_wave_pin), .irq(irq));
`default_nettype wire

// ==== sim/dtc_pins_model.sv ====
// Purpose: Drives the external count and gate pins of the timer block.
// Assumes: Count pins idle high, as with the port pull-ups on.
// Notes: Levels change just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module dtc_pins_model (
  input wire logic clk,
  output logic cntPin0,
  output logic cntPin1,
  output logic gatePin0,
  output logic gatePin1
);
  // ====================
  // Pin drivers
  logic [1:0] cnt = 2'h3;
  assign cntPin0 = cnt[0];
  assign cntPin1 = cnt[1];
  initial begin
    gatePin0 = 1'h0;
    gatePin1 = 1'h0;
  end
  task automatic setGate(input logic g0, input logic g1);
    gatePin0 <= g0;
    gatePin1 <= g1;
  endtask : setGate
  // Levels under one clock may be missed by the device; three clocks is the floor.
  task automatic pulses(input logic ch, input int n, input int w);
    int hold;
    hold = (w < 3) ? 3 : w;
    for (int i = 0; i < n; i++) begin
      cnt[ch] <= 1'h0;
      repeat (hold) @(posedge clk);
      cnt[ch] <= 1'h1;
      repeat (hold) @(posedge clk);
    end
  endtask : pulses
endmodule : dtc_pins_model
`default_nettype wire

// ==== sim/dual_timer_counter_test.sv ====
// Purpose: Register-level tests of the dual timer/counter.
// Assumes: One-cycle ack; count and gate pins come from the pin model.
// Notes: WAVE_DIV is cut to 4 so wave periods stay short.
`timescale 1ns/1ns
`default_nettype none
module dual_timer_counter_test;
  import dtc_pkg::*;
  localparam int unsigned WD = 4;
  logic clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [3:0] sel = 4'h0;
  logic [DTC_ADR_W-1:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, irq, wave, p0, p1, g0, g1;
  logic [7:0] q;
  int nFail = 0, comparisons = 0, n;
  dual_timer_counter #(.WAVE_DIV(WD)) uut (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .timer0_count_pin(p0), .timer1_count_pin(p1),
    .ext_irq0_pin(g0), .ext_irq1_pin(g1), .timer0_wave_pin(wave), .irq(irq));
  dtc_pins_model pins (.clk(clk), .cntPin0(p0), .cntPin1(p1), .gatePin0(g0), .gatePin1(g1));
  // ====================
  // Tasks
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      nFail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d);
    int t;
    t = 0;
    {cyc, stb, we, sel} <= {1'h1, 1'h1, w, 4'h1};
    adr <= {2'h0, ix, 2'h0};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'h1 && t < 20);
    chk("ack", {7'h0, ack}, 8'h01);
    q = rdat[7:0];
    {cyc, stb, we, sel} <= 7'h00;
    @(posedge clk);
  endtask : bus
  task automatic rc(input string nm, input logic [7:0] ix, input logic [7:0] e);
    bus(1'h0, ix, 8'h00);
    chk(nm, q, e);
  endtask : rc
  task automatic arm(input logic [7:0] m, input logic [7:0] lo, input logic [7:0] hi,
    input logic [7:0] c);
    bus(1'h1, DTC_IDX_MODE, m);
    bus(1'h1, DTC_IDX_T0L, lo);
    bus(1'h1, DTC_IDX_T0H, hi);
    bus(1'h1, DTC_IDX_CTRL, c);
  endtask : arm
  task automatic edgeWait(input logic v);
    do begin
      @(posedge clk);
      n++;
    end while (wave !== v && n < 400);
  endtask : edgeWait
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, nFail);
    if (nFail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  // ====================
  // Sequence
  initial begin
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (6000) @(posedge clk);
    nFail++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rc("reset", DTC_IDX_CTRL + 8'(i), 8'h00);
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, DTC_IDX_T0L + 8'(i), 8'hC3 - 8'(i));
      rc("count rw", DTC_IDX_T0L + 8'(i), 8'hC3 - 8'(i));
    end
    bus(1'h1, 8'h10, 8'hFF);
    rc("unmapped", 8'h10, 8'h00);
    bus(1'h1, DTC_IDX_PINSEL, 8'hFF);
    rc("pinsel", DTC_IDX_PINSEL, DTC_PINSEL_MASK);
    $display("test registers finished");
    // Run windows are the gap plus three cycles between the two control writes.
    arm(8'h01, 8'h00, 8'h00, 8'h10);
    repeat (197) @(posedge clk);
    bus(1'h1, DTC_IDX_CTRL, 8'h00);
    rc("rate low", DTC_IDX_T0L, 8'h64);
    repeat (20) @(posedge clk);
    rc("held low", DTC_IDX_T0L, 8'h64);
    arm(8'h00, 8'hFE, 8'h00, 8'h10);
    repeat (5) @(posedge clk);
    bus(1'h1, DTC_IDX_CTRL, 8'h00);
    rc("prescale low", DTC_IDX_T0L, 8'hE2);
    rc("prescale high", DTC_IDX_T0H, 8'h01);
    arm(8'h01, 8'hFF, 8'h00, 8'h10);
    repeat (1) @(posedge clk);
    bus(1'h1, DTC_IDX_CTRL, 8'h00);
    rc("carry low", DTC_IDX_T0L, 8'h01);
    rc("carry high", DTC_IDX_T0H, 8'h01);
    bus(1'h1, DTC_IDX_T1L, 8'h77);
    arm(8'h33, 8'h00, 8'hFF, 8'h40);
    rc("split flag", DTC_IDX_CTRL, 8'hC0);
    bus(1'h1, DTC_IDX_CTRL, 8'h00);
    rc("split high", DTC_IDX_T0H, 8'h02);
    rc("split low", DTC_IDX_T0L, 8'h00);
    rc("stopped t1", DTC_IDX_T1L, 8'h77);
    rc("status", DTC_IDX_ISTAT, 8'h02);
    $display("test timer modes finished");
    bus(1'h1, DTC_IDX_PINSEL, 8'h01);
    bus(1'h1, DTC_IDX_IMASK, 8'h01);
    arm(8'h02, 8'hFE, 8'hFE, 8'h10);
    n = 0;
    edgeWait(1'h0);
    edgeWait(1'h1);
    n = 0;
    edgeWait(1'h0);
    edgeWait(1'h1);
    chk("wave period", 8'(n), 8'(WD * 4));
    rc("flag set", DTC_IDX_CTRL, 8'h30);
    chk("irq", {7'h0, irq}, 8'h01);
    bus(1'h1, DTC_IDX_IMASK, 8'h00);
    chk("masked", {7'h0, irq}, 8'h00);
    bus(1'h1, DTC_IDX_IMASK, 8'h01);
    bus(1'h1, DTC_IDX_CTRL, 8'h20);
    bus(1'h1, DTC_IDX_ACK, 8'h01);
    rc("vector clear", DTC_IDX_CTRL, 8'h00);
    rc("status", DTC_IDX_ISTAT, 8'h01);
    chk("irq cleared", {7'h0, irq}, 8'h00);
    rc("status", DTC_IDX_ISTAT, 8'h00);
    bus(1'h1, DTC_IDX_PINSEL, 8'h00);
    repeat (3) @(posedge clk);
    chk("wave off", {7'h0, wave}, 8'h00);
    $display("test reload and interrupt finished");
    bus(1'h1, DTC_IDX_T1L, 8'h00);
    pins.setGate(1'h0, 1'h1);
    arm(8'h5D, 8'h00, 8'h00, 8'h50);
    pins.pulses(1'h0, 3, 3);
    rc("gated", DTC_IDX_T0L, 8'h00);
    pins.setGate(1'h1, 1'h1);
    repeat (4) @(posedge clk);
    pins.pulses(1'h0, 5, 6);
    pins.pulses(1'h1, 4, 3);
    rc("edges t0", DTC_IDX_T0L, 8'h05);
    rc("edges t1", DTC_IDX_T1L, 8'h04);
    bus(1'h1, DTC_IDX_CTRL, 8'h00);
    pins.pulses(1'h0, 2, 3);
    rc("run off", DTC_IDX_T0L, 8'h05);
    // Timer one in reload and prescaler modes, gated by its irq pin held high.
    bus(1'h1, DTC_IDX_T1L, 8'hFE);
    bus(1'h1, DTC_IDX_T1H, 8'hF0);
    bus(1'h1, DTC_IDX_MODE, 8'hA0);
    bus(1'h1, DTC_IDX_CTRL, 8'h40);
    repeat (3) @(posedge clk);
    bus(1'h1, DTC_IDX_CTRL, 8'h00);
    rc("reload t1", DTC_IDX_T1L, 8'hF1);
    rc("t1 status", DTC_IDX_ISTAT, 8'h02);
    bus(1'h1, DTC_IDX_T1L, 8'h1F);
    bus(1'h1, DTC_IDX_MODE, 8'h80);
    bus(1'h1, DTC_IDX_CTRL, 8'h40);
    repeat (1) @(posedge clk);
    bus(1'h1, DTC_IDX_CTRL, 8'h00);
    rc("prescale t1 low", DTC_IDX_T1L, 8'h01);
    rc("prescale t1 high", DTC_IDX_T1H, 8'hF1);
    $display("test counter and gate finished");
    print_verdict();
  end
endmodule : dual_timer_counter_test
`default_nettype wire
